// [hdl/thermal_peak_and_hottest_regs.sv]
// register bank for peak capture, hottest-diode compare and identity bytes
//
// Operation
// - Per channel, code 0-7 picks 2..129 samples; codes 8-F pick 257.
// - Two sample-count registers, channel one at 43h, channel two at 48h.
// - Per channel read-only byte holds integer sample-period maximum, resets zero.
// - Period-maximum low byte holds fraction in bits 7:5, 0.125 degree steps.
// - Per channel (external diodes one and two) read-only byte holds integer overall maximum, resets zero.
// - Overall-maximum low byte holds fraction in bits 7:5; lower bits unused.
// - Filter select bits 1:0 choose external measurement filtering level.
// - Read-only byte gives integer temperature of hottest enabled diode.
// - Hottest low byte gives fraction in bits 7:5, 0.125 degree steps.
// - Status bit 0 internal, bits 1-4 external diodes; set means hottest.
// - Setup bits 0-4 include matching source in compare; reset zero.
// - Bit 5 set makes alert assert when hottest identity changes.
// - Offset FEh returns a fixed read-only maker code.
// - Offset FFh returns a read-only die revision value.
// - Slope calculation runs only while its enable bit is set.
`timescale 1ns/1ps
module thermal_peak_and_hottest_regs
  import thermal_pkg::*;
#(
  parameter logic [7:0] PART_CODE   = 8'h5A,  // arbitrary value
  parameter logic [7:0] MAKER_CODE  = 8'hA5,  // arbitrary value
  parameter logic [7:0] DIE_VERSION = 8'h01   // arbitrary value
)(
  // clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_n,
  // register port from the management bus engine
  input  wire logic [7:0]                 i_reg_addr,
  input  wire logic                       i_reg_wr,
  input  wire logic [7:0]                 i_reg_wdata,
  input  wire logic                       i_reg_rd,
  output logic [7:0]                      o_reg_rdata,
  // measurement results
  input  wire logic                       i_sample_valid,
  input  wire temp_type [NUM_SOURCES-1:0] i_temps,
  input  wire logic                       i_period_start,
  // slope calculation control
  input  wire logic                       i_slope_calc_enable,
  output logic [NUM_ROC_CH-1:0]           o_slope_calc_run,
  output logic [NUM_ROC_CH-1:0][SAMPLES_W-1:0] o_slope_samples,
  // measurement filter
  output logic [FILTER_W-1:0]             o_filter_level,
  // alert pin, active low
  output logic                            o_alert_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_ROC_CH-1:0][SMPL_CODE_W-1:0] smpl_code;
    logic [FILTER_W-1:0]                    filter;
    logic [HOT_ALERT_BIT:0]                 hot_setup;
    logic                                   alert_pending;
    logic [7:0]                             rdata;
    logic [NUM_ROC_CH-1:0]                  run;
    logic [NUM_ROC_CH-1:0][SAMPLES_W-1:0]   samples;
    logic                                   alert_n;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // decoded count must agree with the reset code, or the first run is off
  localparam logic [SAMPLES_W-1:0] SAMPLES_RST = slope_samples(SMPL_CODE_RST);

  // ----------------------------------------------------------------
  // peak capture on the two external channels
  // ----------------------------------------------------------------
  peak_type [NUM_ROC_CH-1:0] peaks;

  // external diodes one and two are sources 1 and 2
  genvar ch;
  generate
    for (ch = 0; ch < NUM_ROC_CH; ch++) begin : g_peak
      peak_tracker u_peak (
        .i_clk_sys      (i_clk_sys),
        .i_rst_n        (i_rst_n),
        .i_sample_valid (i_sample_valid),
        .i_sample       (i_temps[ch+1]),
        .i_period_start (i_period_start),
        .o_peak         (peaks[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // hottest comparator
  // ----------------------------------------------------------------
  temp_type               hottest;
  logic [NUM_SOURCES-1:0] hot_flags;
  logic                   hot_changed;

  hottest_compare u_hottest (
    .i_clk_sys      (i_clk_sys),
    .i_rst_n        (i_rst_n),
    .i_sample_valid (i_sample_valid),
    .i_temps        (i_temps),
    .i_enables      (state_reg.hot_setup[NUM_SOURCES-1:0]),
    .o_hottest      (hottest),
    .o_flags        (hot_flags),
    .o_changed      (hot_changed)
  );

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    case (addr)
      ADDR_SMPL_CH1:     return 8'(state_reg.smpl_code[0]);
      ADDR_SMPL_CH2:     return 8'(state_reg.smpl_code[1]);
      ADDR_PER_INT_CH1:  return peaks[0].period_max.int_byte;
      ADDR_PER_FRAC_CH1: return frac_byte(peaks[0].period_max);
      ADDR_PER_INT_CH2:  return peaks[1].period_max.int_byte;
      ADDR_PER_FRAC_CH2: return frac_byte(peaks[1].period_max);
      ADDR_GBL_INT_CH1:  return peaks[0].overall_max.int_byte;
      ADDR_GBL_FRAC_CH1: return frac_byte(peaks[0].overall_max);
      ADDR_GBL_INT_CH2:  return peaks[1].overall_max.int_byte;
      ADDR_GBL_FRAC_CH2: return frac_byte(peaks[1].overall_max);
      ADDR_FILTER_SEL:   return 8'(state_reg.filter);
      ADDR_HOT_INT:      return hottest.int_byte;
      ADDR_HOT_FRAC:     return frac_byte(hottest);
      ADDR_HOT_FLAGS:    return 8'(hot_flags);
      ADDR_HOT_SETUP:    return 8'(state_reg.hot_setup);
      ADDR_PART_ID:      return PART_CODE;
      ADDR_MAKER_ID:     return MAKER_CODE;
      ADDR_REVISION:     return DIE_VERSION;
      default:           return RDATA_IDLE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // identity and result bytes have no write path, so writes there drop
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_SMPL_CH1: begin
          state_next.smpl_code[0] = i_reg_wdata[SMPL_CODE_W-1:0];
        end
        ADDR_SMPL_CH2: begin
          state_next.smpl_code[1] = i_reg_wdata[SMPL_CODE_W-1:0];
        end
        ADDR_FILTER_SEL: begin
          state_next.filter = i_reg_wdata[FILTER_W-1:0];
        end
        ADDR_HOT_SETUP: begin
          state_next.hot_setup = i_reg_wdata[HOT_ALERT_BIT:0];
        end
        default: begin
        end
      endcase
    end

    if (i_reg_rd) begin
      state_next.rdata = read_mux(i_reg_addr);
    end

    // reading the status clears the pending alert; a new change wins
    if (i_reg_rd && (i_reg_addr == ADDR_HOT_FLAGS)) begin
      state_next.alert_pending = 1'b0;
    end
    if (hot_changed && state_reg.hot_setup[HOT_ALERT_BIT]) begin
      state_next.alert_pending = 1'b1;
    end
    // dropping the enable withdraws any alert already raised
    if (!state_next.hot_setup[HOT_ALERT_BIT]) begin
      state_next.alert_pending = 1'b0;
    end
    state_next.alert_n = !state_next.alert_pending;

    for (int i = 0; i < NUM_ROC_CH; i++) begin
      state_next.samples[i] = slope_samples(state_next.smpl_code[i]);
      state_next.run[i]     = i_slope_calc_enable;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '{smpl_code:     {NUM_ROC_CH{SMPL_CODE_RST}},
                     filter:        FILTER_RST,
                     hot_setup:     HOT_SETUP_RST,
                     alert_pending: 1'b0,
                     rdata:         RDATA_IDLE,
                     run:           '0,
                     samples:       {NUM_ROC_CH{SAMPLES_RST}},
                     alert_n:       1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata      = state_reg.rdata;
  assign o_slope_calc_run = state_reg.run;
  assign o_slope_samples  = state_reg.samples;
  assign o_filter_level   = state_reg.filter;
  assign o_alert_n        = state_reg.alert_n;

endmodule

// [pkg/thermal_pkg.sv]
// shared constants, types and helpers for the thermal register bank
package thermal_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SMPL_CH1       = 8'h43;
  localparam logic [7:0] ADDR_SMPL_CH2       = 8'h48;
  localparam logic [7:0] ADDR_PER_INT_CH1    = 8'h49;
  localparam logic [7:0] ADDR_PER_FRAC_CH1   = 8'h4A;
  localparam logic [7:0] ADDR_PER_INT_CH2    = 8'h4B;
  localparam logic [7:0] ADDR_PER_FRAC_CH2   = 8'h4C;
  localparam logic [7:0] ADDR_GBL_INT_CH1    = 8'h4D;
  localparam logic [7:0] ADDR_GBL_FRAC_CH1   = 8'h4E;
  localparam logic [7:0] ADDR_GBL_INT_CH2    = 8'h4F;
  localparam logic [7:0] ADDR_GBL_FRAC_CH2   = 8'h50;
  localparam logic [7:0] ADDR_FILTER_SEL     = 8'h51;
  localparam logic [7:0] ADDR_HOT_INT        = 8'h6A;
  localparam logic [7:0] ADDR_HOT_FRAC       = 8'h6B;
  localparam logic [7:0] ADDR_HOT_FLAGS      = 8'h6C;
  localparam logic [7:0] ADDR_HOT_SETUP      = 8'h6D;
  localparam logic [7:0] ADDR_PART_ID        = 8'hFD;
  localparam logic [7:0] ADDR_MAKER_ID       = 8'hFE;
  localparam logic [7:0] ADDR_REVISION       = 8'hFF;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         SMPL_CODE_W         = 4;
  localparam int         FILTER_W            = 2;
  localparam int         NUM_SOURCES         = 5;
  localparam int         NUM_ROC_CH          = 2;
  localparam int         HOT_ALERT_BIT       = 5;
  localparam int         FRAC_W              = 3;
  localparam int         FRAC_LSB            = 5;
  localparam int         SAMPLES_W           = 9;
  localparam logic [3:0] SMPL_CODE_RST       = 4'h0;
  localparam logic [1:0] FILTER_RST          = 2'h0;
  localparam logic [5:0] HOT_SETUP_RST       = 6'h00;
  localparam logic [7:0] RDATA_IDLE          = 8'h00;
  localparam logic [3:0] SMPL_CODE_SAT       = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        int_byte;
    logic [FRAC_W-1:0] frac;
  } temp_type;

  localparam temp_type TEMP_ZERO = '{int_byte: 8'h00, frac: 3'h0};

  typedef struct packed {
    temp_type period_max;
    temp_type overall_max;
  } peak_type;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic temp_above(input temp_type a, input temp_type b);
    return {a.int_byte, a.frac} > {b.int_byte, b.frac};
  endfunction

  function automatic logic [7:0] frac_byte(input temp_type t);
    return {t.frac, 5'h00};
  endfunction

  function automatic logic [SAMPLES_W-1:0] slope_samples(input logic [3:0] code);
    if (code >= SMPL_CODE_SAT) begin
      return 9'h101;
    end
    return 9'(9'h001 << code) + 9'h001;
  endfunction

endpackage

// [hdl/peak_tracker.sv]
// per-channel sample-period and overall maximum temperature capture
`timescale 1ns/1ps
module peak_tracker
  import thermal_pkg::*;
(
  // clock and reset
  input  wire logic     i_clk_sys,
  input  wire logic     i_rst_n,
  // sample stream
  input  wire logic     i_sample_valid,
  input  wire temp_type i_sample,
  input  wire logic     i_period_start,
  // captured peaks
  output peak_type      o_peak
);

  typedef struct packed {
    peak_type peak;
    logic     period_open;
  } state_type;

  state_type state_reg;
  state_type state_next;

  always_comb begin
    state_next = state_reg;
    // a new period forgets the old peak; its first sample loads directly
    if (i_period_start) begin
      state_next.period_open = 1'b0;
    end
    if (i_sample_valid) begin
      if (i_period_start || !state_reg.period_open ||
          temp_above(i_sample, state_reg.peak.period_max)) begin
        state_next.peak.period_max = i_sample;
      end
      state_next.period_open = 1'b1;
      if (temp_above(i_sample, state_reg.peak.overall_max)) begin
        state_next.peak.overall_max = i_sample;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '{peak: '{period_max: TEMP_ZERO, overall_max: TEMP_ZERO},
                     period_open: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_peak = state_reg.peak;

endmodule

// [hdl/hottest_compare.sv]
// hottest-of comparator over the enabled temperature sources
`timescale 1ns/1ps
module hottest_compare
  import thermal_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  // sample set
  input  wire logic                   i_sample_valid,
  input  wire temp_type [NUM_SOURCES-1:0] i_temps,
  input  wire logic [NUM_SOURCES-1:0] i_enables,
  // result
  output temp_type                    o_hottest,
  output logic [NUM_SOURCES-1:0]      o_flags,
  output logic                        o_changed
);

  typedef struct packed {
    temp_type                 hottest;
    logic [NUM_SOURCES-1:0]   flags;
    logic                     changed;
  } state_type;

  state_type state_reg;
  state_type state_next;

  always_comb begin
    temp_type               best;
    logic [NUM_SOURCES-1:0] win;
    logic                   found;
    best       = TEMP_ZERO;
    win        = '0;
    found      = 1'b0;
    state_next = state_reg;
    state_next.changed = 1'b0;
    // strict compare keeps the lowest-numbered source on a tie
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (i_enables[i] && (!found || temp_above(i_temps[i], best))) begin
        best  = i_temps[i];
        win   = NUM_SOURCES'(1) << i;
        found = 1'b1;
      end
    end
    if (i_sample_valid) begin
      state_next.hottest = best;
      state_next.flags   = win;
      state_next.changed = (win != state_reg.flags) && found && (state_reg.flags != '0);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '{hottest: TEMP_ZERO, flags: '0, changed: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_hottest = state_reg.hottest;
  assign o_flags   = state_reg.flags;
  assign o_changed = state_reg.changed;

endmodule

// [bench/thermal_regs_monitor.sv]
// bound checker on the register bank ports
`timescale 1ns/1ps
module thermal_regs_monitor
  import thermal_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'hA5,
  parameter logic [7:0] DIE_VERSION = 8'h01
)(
  // clock and reset
  input wire logic                            i_clk_sys,
  input wire logic                            i_rst_n,
  // register port
  input wire logic [7:0]                      i_reg_addr,
  input wire logic                            i_reg_wr,
  input wire logic [7:0]                      i_reg_wdata,
  input wire logic                            i_reg_rd,
  input wire logic [7:0]                      o_reg_rdata,
  // measurement side
  input wire logic                            i_sample_valid,
  input wire logic                            i_slope_calc_enable,
  input wire logic [NUM_ROC_CH-1:0]           o_slope_calc_run,
  input wire logic [NUM_ROC_CH-1:0][SAMPLES_W-1:0] o_slope_samples,
  input wire logic [FILTER_W-1:0]             o_filter_level,
  input wire logic                            o_alert_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // independent decode, kept apart from the package helper
  function automatic logic [8:0] dec(input logic [3:0] c);
    return c[3] ? 9'h101 : 9'(9'h001 << c[2:0]) + 9'h001;
  endfunction
  sequence s_rd(logic [7:0] a);
    i_reg_rd && i_reg_addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    i_reg_wr && i_reg_addr == a;
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  // waits two edges so either output latency passes
  a_count_decode: assert property (s_wr(8'h43) ##1 !i_reg_wr |=>
    o_slope_samples[0] == dec($past(i_reg_wdata[3:0], 2)))
    else $error("sample count decode wrong");
  a_count_legal: assert property ($onehot(o_slope_samples[0] - 9'h001) &&
    $onehot(o_slope_samples[1] - 9'h001)) else $error("illegal sample count");
  a_filter_write: assert property (s_wr(8'h51) ##1 !i_reg_wr |=>
    o_filter_level == $past(i_reg_wdata[1:0], 2)) else $error("filter level wrong");
  a_slope_follow: assert property ($rose(i_slope_calc_enable) ||
    $fell(i_slope_calc_enable) |=> o_slope_calc_run == {2{$past(i_slope_calc_enable)}})
    else $error("slope run does not follow enable");
  a_maker_read: assert property (s_rd(8'hFE) |=> o_reg_rdata == MAKER_CODE)
    else $error("maker code wrong");
  a_revision_read: assert property (s_rd(8'hFF) |=> o_reg_rdata == DIE_VERSION)
    else $error("revision wrong");
  a_frac_low_zero: assert property (i_reg_rd &&
    i_reg_addr inside {8'h4A, 8'h4C, 8'h4E, 8'h50, 8'h6B} |=> o_reg_rdata[4:0] == 5'h00)
    else $error("fraction byte low bits set");
  a_flags_single: assert property (s_rd(8'h6C) |=> $onehot0(o_reg_rdata) &&
    o_reg_rdata[7:5] == 3'h0) else $error("hottest flags not single");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  a_alert_clear: assert property (s_rd(8'h6C) ##0 !$past(i_sample_valid) |=> o_alert_n)
    else $error("alert not cleared by status read");
  a_alert_drop: assert property (s_wr(8'h6D) ##0 !i_reg_wdata[HOT_ALERT_BIT]
    |=> ##1 o_alert_n) else $error("alert held with option off");
endmodule

// [bench/reg_host.sv]
// host side of the register port, strobes launched on the falling edge
`timescale 1ns/1ps
module reg_host (
  // clock
  input  wire logic       i_clk_sys,
  // register port
  input  wire logic [7:0] i_rdata,
  output logic [7:0]      o_addr,
  output logic            o_wr,
  output logic [7:0]      o_wdata,
  output logic            o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule

// [bench/thermal_peak_and_hottest_regs_test.sv]
// self-checking bench for the thermal register bank
`timescale 1ns/1ps
module thermal_peak_and_hottest_regs_test;
  import thermal_pkg::*;
  logic                                  clk_sys, rst_n, wr, rd, valid, pstart, slope_en;
  logic                                  alert_n;
  logic [7:0]                            addr, wdata, rdata;
  logic [1:0]                            run, filt;
  logic [NUM_ROC_CH-1:0][SAMPLES_W-1:0]  smpl;
  temp_type [NUM_SOURCES-1:0]            temps;
  int                                    n_errors, checks;

  thermal_peak_and_hottest_regs dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_sample_valid(valid), .i_temps(temps),
    .i_period_start(pstart), .i_slope_calc_enable(slope_en), .o_slope_calc_run(run),
    .o_slope_samples(smpl), .o_filter_level(filt), .o_alert_n(alert_n));
  reg_host host (.i_clk_sys(clk_sys), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_wdata(wdata), .o_rd(rd));

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk($sformatf("reg %h", a), {1'b0, exp}, {1'b0, d});
  endtask
  // one sample set, then time for compare and alert to settle
  task automatic put(input logic [54:0] t, input logic ps);
    @(negedge clk_sys);
    temps = t;
    valid = 1'b1;
    pstart = ps;
    @(negedge clk_sys);
    valid = 1'b0;
    pstart = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic final_report();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int a = 8'h49; a <= 8'h50; a++) rchk(8'(a), 8'h00);
    rchk(8'h6D, 8'h00);
    rchk(8'h00, 8'h00);
    chk("alert", 9'h001, {8'h00, alert_n});
    chk("count rst", 9'h002, smpl[0]);
    chk("count rst 2", 9'h002, smpl[1]);
  endtask
  task automatic t_ident();
    host.wr_reg(8'hFE, 8'h00);
    host.wr_reg(8'hFF, 8'h00);
    rchk(8'hFD, 8'h5A);
    rchk(8'hFE, 8'hA5);
    rchk(8'hFF, 8'h01);
  endtask
  task automatic t_count();
    logic [8:0] e;
    for (int c = 0; c < 16; c++) begin
      host.wr_reg(8'h43, {4'hA, 4'(c)});
      host.wr_reg(8'h48, {4'h5, 4'(15 - c)});
      @(negedge clk_sys);
      e = c >= 8 ? 9'h101 : 9'((1 << c) + 1);
      chk("count ch1", e, smpl[0]);
      e = c <= 7 ? 9'h101 : 9'((1 << (15 - c)) + 1);
      chk("count ch2", e, smpl[1]);
      rchk(8'h43, {4'h0, 4'(c)});
    end
  endtask
  task automatic t_filter();
    for (int f = 0; f < 4; f++) begin
      host.wr_reg(8'h51, {6'h3F, 2'(f)});
      @(negedge clk_sys);
      chk("filter", 9'(f), {7'h00, filt});
      rchk(8'h51, {6'h00, 2'(f)});
    end
  endtask
  task automatic t_slope();
    slope_en = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("run on", 9'h003, {7'h00, run});
    slope_en = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("run off", 9'h000, {7'h00, run});
  endtask
  // sources 4..0: 10.0, 30.5, 25.0, 30.5, 20.0
  task automatic t_hot_peak();
    host.wr_reg(8'h6D, 8'h1F);
    put({11'h050, 11'h0F4, 11'h0C8, 11'h0F4, 11'h0A0}, 1'b0);
    rchk(8'h6A, 8'h1E);
    rchk(8'h6B, 8'h80);
    rchk(8'h6C, 8'h02);
    host.wr_reg(8'h6D, 8'h1D);
    put({11'h050, 11'h0F4, 11'h0C8, 11'h0F4, 11'h0A0}, 1'b0);
    rchk(8'h6C, 8'h08);
    chk("alert off", 9'h001, {8'h00, alert_n});
    rchk(8'h4D, 8'h1E);
    rchk(8'h4E, 8'h80);
    rchk(8'h4F, 8'h19);
    rchk(8'h4B, 8'h19);
    put({11'h050, 11'h0F4, 11'h058, 11'h061, 11'h0A0}, 1'b1);
    rchk(8'h49, 8'h0C);
    rchk(8'h4A, 8'h20);
    rchk(8'h4B, 8'h0B);
    rchk(8'h4D, 8'h1E);
    rchk(8'h4E, 8'h80);
  endtask
  task automatic t_alert();
    host.wr_reg(8'h6D, 8'h3D);
    put({11'h140, 11'h0F4, 11'h058, 11'h061, 11'h0A0}, 1'b0);
    chk("alert set", 9'h000, {8'h00, alert_n});
    rchk(8'h6C, 8'h10);
    chk("alert read", 9'h001, {8'h00, alert_n});
    put({11'h140, 11'h0F4, 11'h058, 11'h061, 11'h0A0}, 1'b0);
    chk("alert same", 9'h001, {8'h00, alert_n});
    put({11'h140, 11'h0F4, 11'h058, 11'h061, 11'h190}, 1'b0);
    chk("alert again", 9'h000, {8'h00, alert_n});
    host.wr_reg(8'h6D, 8'h1D);
    repeat (2) @(negedge clk_sys);
    chk("alert drop", 9'h001, {8'h00, alert_n});
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    valid = 1'b0;
    pstart = 1'b0;
    slope_en = 1'b0;
    temps = '0;
    n_errors = 0;
    checks = 0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_ident();
    t_count();
    t_filter();
    t_slope();
    t_hot_peak();
    t_alert();
    final_report();
  end
endmodule

bind thermal_peak_and_hottest_regs thermal_regs_monitor #(.MAKER_CODE(MAKER_CODE),
  .DIE_VERSION(DIE_VERSION)) mon (.i_clk_sys, .i_rst_n, .i_reg_addr, .i_reg_wr,
  .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .i_sample_valid, .i_slope_calc_enable,
  .o_slope_calc_run, .o_slope_samples, .o_filter_level, .o_alert_n);
